// >>> src/macrocell_map.vh
// constants shared by the logic-block slice
`ifndef MACROCELL_MAP_VH
`define MACROCELL_MAP_VH

// ----------------------------------------------------------------
// block dimensions
// ----------------------------------------------------------------
`define MC_COUNT 16
`define PT_COUNT 64
`define CLUSTER_TERMS 4
`define HALF_SIZE 8
`define MAX_TERMS_PER_MC 12

// ----------------------------------------------------------------
// term steering codes, two bits per logic product term
// ----------------------------------------------------------------
`define STEER_NONE 2'h0
`define STEER_LEFT 2'h1
`define STEER_OWN 2'h2
`define STEER_RIGHT 2'h3

// ----------------------------------------------------------------
// pin driver modes, two bits per pin
// ----------------------------------------------------------------
`define OE_ALWAYS 2'h0
`define OE_NEVER 2'h1
`define OE_TERM 2'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FF_INIT 1'h0
`define PIN_OUT_INIT 16'h0000
`define PIN_OE_INIT 16'h0000
`define CLK_PREV_INIT 2'h0

`endif

// >>> src/sync_bits.v
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none

module sync_bits #(
	parameter WIDTH = 1
) (
	input wire clk_sys_in,
	input wire rstn_in,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	// first stage is read by the second stage only
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule

`default_nettype wire

// >>> src/storage_cell.v
// one macrocell flip-flop: d or t type with shared clear and set
`timescale 1ns/1ns
`default_nettype none
`include "macrocell_map.vh"

module storage_cell (
	input wire clk_sys_in,
	input wire rstn_in,
	input wire edge_in,
	input wire sum_in,
	input wire t_type_in,
	input wire clear_in,
	input wire set_in,
	output wire q_out
);

	reg q_reg;

	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			q_reg <= `FF_INIT;
		end else if (clear_in) begin
			// clear beats set so both terms high give a known low
			q_reg <= 1'b0;
		end else if (set_in) begin
			q_reg <= 1'b1;
		end else if (edge_in) begin
			if (t_type_in) begin
				q_reg <= q_reg ^ sum_in;
			end else begin
				q_reg <= sum_in;
			end
		end
	end

	assign q_out = q_reg;

endmodule

`default_nettype wire

// >>> src/macrocell_allocator_io.v
// logic-block slice: term allocator, sixteen macrocells and pin cells
// ----------------------------------------------------------------
// How it works
// - sixty-four logic terms are steered among sixteen macrocells.
// - a macrocell sums at most twelve terms.
// - a macrocell reaches its own and neighbouring clusters in its half.
// - each output is registered or combinational, polarity selectable.
// - the result is fed back internally in both configurations.
// - each flip-flop is configured as d type or t type.
// - each flip-flop picks one of two clock pins, also usable as inputs.
// - apart from clear and set, flip-flops change only on a rising edge of the picked clock pin.
// - shared clear and set terms act without waiting for a clock pin.
// - clear and set reach every flip-flop of the block at once.
// - all flip-flops start low after power-up.
// - a pin driver is always on, always off, or gated by a term.
// - a gated pin picks one of two enable terms shared by eight pins.
// - the first eight pins use one enable pair, the last eight another.
// - pins can act as output, input, bidirectional line or bus driver.
// ----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "macrocell_map.vh"

module macrocell_allocator_io (
	input wire clk_sys_in,
	input wire rstn_in,
	input wire [63:0] pterm_in,
	input wire [127:0] steer_cfg_in,
	input wire [15:0] reg_mode_in,
	input wire [15:0] pol_inv_in,
	input wire [15:0] t_type_in,
	input wire [15:0] clk_pick_in,
	input wire [31:0] oe_mode_in,
	input wire [15:0] oe_pick_in,
	input wire [3:0] oe_term_in,
	input wire clear_term_in,
	input wire set_term_in,
	input wire [1:0] clk_pin_in,
	input wire [15:0] io_pin_in,
	output wire [15:0] io_pin_out,
	output wire [15:0] io_pin_oe_out,
	output wire [15:0] mc_feedback_out,
	output wire [15:0] io_feedback_out,
	output wire [1:0] clk_pin_data_out
);

	// ----------------------------------------------------------------
	// pin sampling
	// ----------------------------------------------------------------
	wire [1:0] clk_pin_sync;
	wire [15:0] io_pin_sync;
	reg [1:0] clk_prev_reg;
	wire [1:0] clk_rise;

	sync_bits #(
		.WIDTH(2)
	) u_clk_sync (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.async_in(clk_pin_in),
		.sync_out(clk_pin_sync)
	);

	// pins read back so an undriven pin serves as an input
	sync_bits #(
		.WIDTH(16)
	) u_io_sync (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.async_in(io_pin_in),
		.sync_out(io_pin_sync)
	);

	// clock pins are oversampled, so they must run well below half
	// the system rate to have every rising edge seen
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clk_prev_reg <= `CLK_PREV_INIT;
		end else begin
			clk_prev_reg <= clk_pin_sync;
		end
	end

	assign clk_rise = clk_pin_sync & ~clk_prev_reg;
	assign clk_pin_data_out = clk_pin_sync;
	assign io_feedback_out = io_pin_sync;

	// ----------------------------------------------------------------
	// allocator and macrocells
	// ----------------------------------------------------------------
	wire [15:0] pt_sum;
	wire [15:0] ff_q;
	reg [15:0] mc_result_next;
	reg [15:0] mc_result_reg;

	genvar m;
	genvar k;
	generate
		for (m = 0; m < `MC_COUNT; m = m + 1) begin : g_mc
			wire [3:0] own_hit;
			wire [3:0] from_left;
			wire [3:0] from_right;
			for (k = 0; k < `CLUSTER_TERMS; k = k + 1) begin : g_term
				// a term goes to one macrocell only, by its steer code
				assign own_hit[k] = pterm_in[4*m+k] &
					(steer_cfg_in[2*(4*m+k)+:2] == `STEER_OWN);
				if (m % `HALF_SIZE != 0) begin : g_left
					assign from_left[k] = pterm_in[4*(m-1)+k] &
						(steer_cfg_in[2*(4*(m-1)+k)+:2] ==
						`STEER_RIGHT);
				end else begin : g_no_left
					assign from_left[k] = 1'b0;
				end
				if (m % `HALF_SIZE != `HALF_SIZE - 1) begin : g_right
					assign from_right[k] = pterm_in[4*(m+1)+k] &
						(steer_cfg_in[2*(4*(m+1)+k)+:2] ==
						`STEER_LEFT);
				end else begin : g_no_right
					assign from_right[k] = 1'b0;
				end
			end
			// three clusters of four cap the sum at twelve terms
			assign pt_sum[m] = |{from_left, own_hit, from_right};

			storage_cell u_cell (
				.clk_sys_in(clk_sys_in),
				.rstn_in(rstn_in),
				.edge_in(clk_rise[clk_pick_in[m]]),
				.sum_in(pt_sum[m]),
				.t_type_in(t_type_in[m]),
				.clear_in(clear_term_in),
				.set_in(set_term_in),
				.q_out(ff_q[m])
			);
		end
	endgenerate

	always @* begin
		mc_result_next = (reg_mode_in & ff_q) |
			(~reg_mode_in & pt_sum);
		mc_result_next = mc_result_next ^ pol_inv_in;
	end

	// the combinational path costs one system cycle here because every
	// output leaves from a flip-flop
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mc_result_reg <= `PIN_OUT_INIT;
		end else begin
			mc_result_reg <= mc_result_next;
		end
	end

	assign io_pin_out = mc_result_reg;
	assign mc_feedback_out = mc_result_reg;

	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	wire [1:0] oe_pair_low;
	wire [1:0] oe_pair_high;
	wire [15:0] oe_next;
	reg [15:0] oe_reg;

	// each half of the block owns its own pair of enable terms
	assign oe_pair_low = oe_term_in[1:0];
	assign oe_pair_high = oe_term_in[3:2];

	genvar p;
	generate
		for (p = 0; p < `MC_COUNT; p = p + 1) begin : g_pin
			wire [1:0] pin_mode;
			wire [1:0] pin_pair;
			reg pin_oe;
			assign pin_mode = oe_mode_in[2*p+:2];
			if (p < `HALF_SIZE) begin : g_low
				assign pin_pair = oe_pair_low;
			end else begin : g_high
				assign pin_pair = oe_pair_high;
			end
			always @* begin
				case (pin_mode)
					`OE_ALWAYS: begin
						pin_oe = 1'b1;
					end
					`OE_NEVER: begin
						pin_oe = 1'b0;
					end
					`OE_TERM: begin
						pin_oe = pin_pair[oe_pick_in[p]];
					end
					default: begin
						// unused code behaves as disabled, pin stays an input
						pin_oe = 1'b0;
					end
				endcase
			end
			assign oe_next[p] = pin_oe;
		end
	endgenerate

	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			oe_reg <= `PIN_OE_INIT;
		end else begin
			oe_reg <= oe_next;
		end
	end

	assign io_pin_oe_out = oe_reg;

endmodule

`default_nettype wire

// >>> verification/slice_chk.sv
// concurrent checks on the pins of the logic-block slice
`timescale 1ns/1ns
`default_nettype none
module slice_chk (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic [63:0] pterm_in,
	input wire logic [127:0] steer_cfg_in,
	input wire logic [15:0] reg_mode_in,
	input wire logic [15:0] pol_inv_in,
	input wire logic [31:0] oe_mode_in,
	input wire logic [15:0] oe_pick_in,
	input wire logic [3:0] oe_term_in,
	input wire logic clear_term_in,
	input wire logic set_term_in,
	input wire logic [1:0] clk_pin_in,
	input wire logic [15:0] io_pin_out,
	input wire logic [15:0] io_pin_oe_out,
	input wire logic [15:0] mc_feedback_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	oe_on_a: assert property (oe_mode_in[1:0] == 2'h0 |=> io_pin_oe_out[0])
		else $error("pin 0 driver off");
	oe_off_a: assert property (oe_mode_in[3:2] == 2'h1 |=> !io_pin_oe_out[1])
		else $error("pin 1 driver on");
	oe_gate_a: assert property (oe_mode_in[19:18] == 2'h2 && oe_pick_in[9]
		|=> io_pin_oe_out[9] == $past(oe_term_in[3])) else $error("pin 9 enable");
	oe_low_a: assert property (oe_mode_in[7:6] == 2'h2 && oe_pick_in[3]
		|=> io_pin_oe_out[3] == $past(oe_term_in[1])) else $error("pin 3 enable");
	fb_same_a: assert property (mc_feedback_out == io_pin_out)
		else $error("feedback differs from pin");
	comb_sum_a: assert property (!reg_mode_in[1] && pterm_in[4]
		&& steer_cfg_in[9:8] == 2'h2 |=> io_pin_out[1] != $past(pol_inv_in[1]))
		else $error("comb sum lost");
	clear_all_a: assert property ((clear_term_in ##1 (reg_mode_in == 16'hffff
		&& pol_inv_in == 16'h0)) |=> mc_feedback_out == 16'h0) else $error("clear");
	set_all_a: assert property (((set_term_in && !clear_term_in) ##1
		(reg_mode_in == 16'hffff && pol_inv_in == 16'h0))
		|=> mc_feedback_out == 16'hffff) else $error("set");
	hold_a: assert property ((reg_mode_in == 16'hffff && clk_pin_in == 2'h0
		&& !clear_term_in && !set_term_in && pol_inv_in == 16'h0)[*5]
		|=> $stable(mc_feedback_out)) else $error("flop moved without edge");
	cover property (set_term_in && clear_term_in);
	cover property ($rose(clk_pin_in[1]));
	cover property (oe_mode_in[17:16] == 2'h2 && oe_term_in[2]);
endmodule
bind macrocell_allocator_io slice_chk chk (.*);
`default_nettype wire

// >>> verification/pin_board.sv
// board-side model: clock pins and the lines the device leaves undriven
`timescale 1ns/1ns
`default_nettype none
module pin_board (
	input wire logic [15:0] io_pin_out,
	input wire logic [15:0] io_pin_oe_out,
	input wire logic [15:0] board_val_in,
	input wire logic [15:0] board_en_in,
	output wire logic [15:0] io_pin_in,
	output var logic [1:0] clk_pin_in
);
	// released lines the board does not drive float high through pull-ups, never hold old data
	assign io_pin_in = (io_pin_oe_out & io_pin_out) | (~io_pin_oe_out
		& ((board_en_in & board_val_in) | ~board_en_in));
	initial clk_pin_in = 2'h0;
	task automatic drive_clk(int p, logic v);
		clk_pin_in[p] = v;
	endtask
endmodule
`default_nettype wire

// >>> verification/macrocell_allocator_io_tb_top.sv
// directed bench for the logic-block slice
`timescale 1ns/1ns
`default_nettype none
module macrocell_allocator_io_tb_top;
	logic clk_sys_in, rstn_in, clear_term_in, set_term_in;
	logic [63:0] pterm_in;
	logic [127:0] steer_cfg_in;
	logic [15:0] reg_mode_in, pol_inv_in, t_type_in, clk_pick_in, oe_pick_in;
	logic [15:0] board_val_in, board_en_in;
	logic [31:0] oe_mode_in;
	logic [3:0] oe_term_in;
	wire [15:0] io_pin_in, io_pin_out, io_pin_oe_out;
	wire [15:0] mc_feedback_out, io_feedback_out;
	wire [1:0] clk_pin_in, clk_pin_data_out;
	int fails = 0, checks = 0, cyc = 0;
	macrocell_allocator_io uut (.*);
	pin_board board (.*);
	initial begin
		clk_sys_in = 0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic report_and_stop;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic steer(int j, logic [1:0] c, logic [15:0] e);
		pterm_in = 64'h0;
		pterm_in[j] = 1'b1;
		steer_cfg_in = 128'h0;
		steer_cfg_in[2*j +: 2] = c;
		tick(2);
		chk("comb", e, io_pin_out);
	endtask
	// pulse held long enough to survive the two-flop synchroniser
	task automatic pulse(int p);
		board.drive_clk(p, 1'b1);
		tick(3);
		chk("clk data", 16'h1 << p, {14'h0, clk_pin_data_out});
		board.drive_clk(p, 1'b0);
		tick(5);
	endtask
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		rstn_in = 0;
		{clear_term_in, set_term_in, oe_term_in} = 6'h0;
		{pterm_in, steer_cfg_in, oe_mode_in} = 224'h0;
		{pol_inv_in, t_type_in, oe_pick_in} = 48'h0;
		reg_mode_in = 16'hffff;
		clk_pick_in = 16'h0002;
		board_val_in = 16'ha5c3;
		board_en_in = 16'hff00;
		tick(16);
		chk("reset", 16'h0, io_pin_out | io_pin_oe_out | mc_feedback_out);
		rstn_in = 1;
		tick(2);
		chk("power up", 16'h0, mc_feedback_out);
		pol_inv_in = 16'hffff;
		tick(2);
		chk("polarity", 16'hffff, io_pin_out);
		pol_inv_in = 16'h0;
		reg_mode_in = 16'h0;
		steer(4, 2'h2, 16'h0002);
		steer(4, 2'h1, 16'h0001);
		steer(4, 2'h3, 16'h0004);
		steer(36, 2'h1, 16'h0100);
		steer(0, 2'h1, 16'h0);
		steer(31, 2'h3, 16'h0);
		steer(32, 2'h1, 16'h0);
		steer(63, 2'h3, 16'h0);
		reg_mode_in = 16'hffff;
		steer_cfg_in = 128'h202;
		pterm_in = 64'h11;
		pulse(0);
		chk("d pin0", 16'h0001, mc_feedback_out);
		pulse(1);
		chk("d pin1", 16'h0003, mc_feedback_out);
		t_type_in = 16'h0001;
		pulse(0);
		chk("t toggle", 16'h0002, mc_feedback_out);
		pulse(0);
		chk("t again", 16'h0003, mc_feedback_out);
		pterm_in = 64'h10;
		pulse(0);
		chk("t hold", 16'h0003, mc_feedback_out);
		set_term_in = 1;
		tick(1);
		set_term_in = 0;
		tick(2);
		chk("set", 16'hffff, mc_feedback_out);
		{clear_term_in, set_term_in} = 2'h3;
		tick(1);
		{clear_term_in, set_term_in} = 2'h0;
		tick(2);
		chk("clear", 16'h0, mc_feedback_out);
		oe_mode_in = 32'h000a03a4;
		oe_pick_in = 16'h0208;
		for (int t = 0; t < 16; t++) begin
			oe_term_in = t[3:0];
			tick(2);
			chk("enable", 16'hfce1 | {6'h0, t[3:2], 4'h0, t[1:0], 2'h0}, io_pin_oe_out);
		end
		oe_term_in = 4'h0;
		tick(4);
		chk("io fb", 16'h011e, io_feedback_out);
		set_term_in = 1;
		tick(1);
		set_term_in = 0;
		rstn_in = 0;
		tick(2);
		chk("mid reset", 16'h0, mc_feedback_out | io_pin_oe_out);
		rstn_in = 1;
		tick(2);
		chk("restart", 16'h0, mc_feedback_out);
		report_and_stop();
	end
endmodule
`default_nettype wire
